/* rtl/bridge_bound_ctl.sv */
// Write disconnect and read prefetch boundary control of a PCI bridge.
// Assumes every input is driven by bridge core logic on the same clock.
//
// Notes on behaviour
// - Delayed write ends with target disconnect after exactly one data phase.
// - Chip control bit 1 selects the posted write disconnect boundary.
// - Bit set disconnects memory writes at a valid cache line, clear at 4KB.
// - Write-invalidate with valid line size stops at line only if room lacks.
// - Posted data accepted while a dword fits; disconnect when buffer fills.
// - Delayed write accepted whenever a delayed queue entry is free.
// - Fast back-to-back writes posted; retry second when space lacks.
// - Fast back-to-back needs command or bridge control enable set.
// - Every read is delayed, classed prefetchable or non-prefetchable.
// - Prefetchable reads drive all byte enables active on every phase.
// - Read line, read multiple, prefetchable memory read all prefetch.
// - Non-prefetchable read fetches one dword, disconnects after it.
// - I/O, config and non-prefetchable memory reads fetch one dword.
// - Prefetch stops at boundary; initiator disconnected with last data.
// - Prefetched data left untaken is discarded.
// - Flow-through prefetches to 4KB boundary or initiator frame end.
// - Read and read line boundary: 16 dwords or one cache line.
// - Read multiple boundary: 32 dwords or two cache lines.
// - Downstream read prefetches in prefetchable space; upstream by setting.
// - Cache line length counts dwords.
// - Flow-through starts when initiator takes data before fetch ends.
module bridge_bound_ctl
  import bridge_bound_pkg::*;
#(
  parameter int PW_W = 8
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             cfg_wr,
  input  wire logic             cfg_rd,
  input  wire logic [7:0]       cfg_addr,
  input  wire logic [7:0]       cfg_wdata,
  output logic      [7:0]       cfg_rdata,
  input  wire logic             wr_start,
  input  wire logic [3:0]       wr_cmd,
  input  wire logic [29:0]      wr_addr,
  input  wire logic             wr_upstream,
  input  wire logic             wr_fb2b,
  input  wire logic             wr_phase,
  input  wire logic             wr_last,
  input  wire logic [PW_W-1:0]  pw_free_dw,
  input  wire logic             dtq_free,
  output logic                  wr_ack,
  output logic                  wr_disc,
  output logic                  wr_retry,
  output logic                  wr_as_mw,
  input  wire logic             rd_start,
  input  wire logic [3:0]       rd_cmd,
  input  wire logic [29:0]      rd_addr,
  input  wire logic [3:0]       rd_be,
  input  wire logic             rd_upstream,
  input  wire logic             rd_pref_space,
  input  wire logic             tgt_phase,
  input  wire logic             tgt_stop,
  input  wire logic             ini_phase,
  input  wire logic             ini_end,
  output logic                  rd_prefetch,
  output logic      [3:0]       rd_be_out,
  output logic      [29:0]      rd_tgt_addr,
  output logic                  rd_tgt_last,
  output logic                  rd_ini_stop,
  output logic                  rd_flow,
  output logic                  rd_discard
);

  if (PW_W < 5 || PW_W > 15) begin : g_chk
    $error("PW_W must lie between 5 and 15");
  end

  typedef struct packed {
    wr_st_t      wr_st;
    rd_st_t      rd_st;
    logic [7:0]  chip_ctrl;
    logic [7:0]  cache_line_length;
    logic [7:0]  cmd_hi;
    logic [7:0]  brctl_lo;
    logic [7:0]  rdata;
    logic [29:0] w_addr;
    logic [9:0]  w_mask;
    logic [9:0]  w_lmask;
    logic        w_mwi;
    logic        w_ack;
    logic        w_disc;
    logic        w_retry;
    logic        w_as_mw;
    logic [29:0] r_addr;
    logic [9:0]  r_mask;
    logic        r_pref;
    logic [3:0]  r_be;
    logic        r_tlast;
    logic        r_tdone;
    logic        r_flow;
    logic        r_istop;
    logic        r_discard;
    logic [10:0] r_fcnt;
    logic [10:0] r_dcnt;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  logic        cls_ok;
  logic [9:0]  line_mask;
  logic        fb2b_ok;
  logic [29:0] w_na;
  logic [15:0] w_room;
  logic        w_line_end;
  logic        w_cur_line_end;
  logic [29:0] r_na;
  logic [10:0] r_fn;
  logic [10:0] r_dn;
  logic        r_tdn;
  logic [9:0]  r_bmask;

  always_comb begin
    st_nxt    = st_r;
    st_nxt.w_retry   = 1'b0;
    st_nxt.r_discard = 1'b0;
    // Line length in dwords; legal values are powers of two up to 16
    cls_ok    = (st_r.cache_line_length == 8'h01) || (st_r.cache_line_length == 8'h02) ||
                (st_r.cache_line_length == 8'h04) || (st_r.cache_line_length == 8'h08) ||
                (st_r.cache_line_length == 8'h10);
    line_mask = 10'(st_r.cache_line_length) - 10'h1;
    fb2b_ok   = !wr_fb2b || (wr_upstream ? st_r.cmd_hi[FB2B_CMD_BIT]
                                         : st_r.brctl_lo[FB2B_BRC_BIT]);

    if (cfg_wr) begin
      case (cfg_addr)
        CLS_OFS:       st_nxt.cache_line_length       = cfg_wdata;
        CMD_HI_OFS:    st_nxt.cmd_hi    = cfg_wdata;
        BRCTL_LO_OFS:  st_nxt.brctl_lo  = cfg_wdata;
        CHIP_CTRL_OFS: st_nxt.chip_ctrl = cfg_wdata;
        default:       st_nxt.cache_line_length       = st_r.cache_line_length;
      endcase
    end
    if (cfg_rd) begin
      case (cfg_addr)
        CLS_OFS:       st_nxt.rdata = st_r.cache_line_length;
        CMD_HI_OFS:    st_nxt.rdata = st_r.cmd_hi;
        BRCTL_LO_OFS:  st_nxt.rdata = st_r.brctl_lo;
        CHIP_CTRL_OFS: st_nxt.rdata = st_r.chip_ctrl;
        STATUS_OFS:    st_nxt.rdata = {st_r.r_flow, st_r.r_tdone,
                                       st_r.r_pref, st_r.w_as_mw,
                                       st_r.rd_st, st_r.wr_st};
        default:       st_nxt.rdata = 8'h00;
      endcase
    end

    // Posted write: next address and room left for the pending phase
    w_na   = wr_phase ? st_r.w_addr + 30'h1 : st_r.w_addr;
    w_room = 16'(pw_free_dw);
    if (wr_phase && w_room != 16'h0) begin
      w_room = w_room - 16'h1;
    end
    w_line_end     = ((w_na[9:0] + 10'h1) & st_r.w_lmask) == 10'h0;
    w_cur_line_end = ((st_r.w_addr[9:0] + 10'h1) & st_r.w_lmask) == 10'h0;

    case (st_r.wr_st)
      W_IDLE: begin
        if (wr_start) begin
          if (wr_cmd == CMD_MEM_WR || wr_cmd == CMD_MEM_WRI) begin
            if (pw_free_dw != '0 && fb2b_ok) begin
              st_nxt.wr_st   = W_POST;
              st_nxt.w_addr  = wr_addr;
              st_nxt.w_ack   = 1'b1;
              st_nxt.w_as_mw = 1'b0;
              st_nxt.w_mwi   = (wr_cmd == CMD_MEM_WRI) && cls_ok;
              st_nxt.w_lmask = cls_ok ? line_mask : MASK_4KB;
              if (wr_cmd == CMD_MEM_WR && st_r.chip_ctrl[MWD_BIT] &&
                  cls_ok) begin
                st_nxt.w_mask = line_mask;
              end else begin
                st_nxt.w_mask = MASK_4KB;
              end
              st_nxt.w_disc = (pw_free_dw == PW_W'(1)) ||
                ((wr_addr[9:0] + 10'h1) &
                 ((wr_cmd == CMD_MEM_WR && st_r.chip_ctrl[MWD_BIT] &&
                   cls_ok) ? line_mask : MASK_4KB)) == 10'h0;
            end else begin
              st_nxt.w_retry = 1'b1;
            end
          end else if (wr_cmd == CMD_IO_WR || wr_cmd == CMD_CFG_WR) begin
            if (dtq_free && fb2b_ok) begin
              st_nxt.wr_st  = W_DLY;
              st_nxt.w_ack  = 1'b1;
              st_nxt.w_disc = 1'b1;
            end else begin
              st_nxt.w_retry = 1'b1;
            end
          end
        end
      end
      W_POST: begin
        if (wr_phase && (st_r.w_disc || wr_last)) begin
          st_nxt.wr_st   = W_IDLE;
          st_nxt.w_ack   = 1'b0;
          st_nxt.w_disc  = 1'b0;
          // Write-invalidate cut short of its line becomes a plain write
          st_nxt.w_as_mw = st_r.w_mwi && !w_cur_line_end;
        end else begin
          st_nxt.w_addr = w_na;
          st_nxt.w_disc = (((w_na[9:0] + 10'h1) & st_r.w_mask) == 10'h0) ||
                          (w_room <= 16'h1) ||
                          (st_r.w_mwi && w_line_end &&
                           (w_room - 16'h1) < 16'(st_r.cache_line_length));
        end
      end
      W_DLY: begin
        if (wr_phase) begin
          st_nxt.wr_st  = W_IDLE;
          st_nxt.w_ack  = 1'b0;
          st_nxt.w_disc = 1'b0;
        end
      end
      default: st_nxt.wr_st = W_IDLE;
    endcase

    // Read: target side fetch and initiator side delivery
    r_na    = tgt_phase ? st_r.r_addr + 30'h1 : st_r.r_addr;
    r_fn    = tgt_phase ? st_r.r_fcnt + 11'h1 : st_r.r_fcnt;
    r_dn    = ini_phase ? st_r.r_dcnt + 11'h1 : st_r.r_dcnt;
    r_tdn   = st_r.r_tdone || (tgt_phase && (st_r.r_tlast || tgt_stop));
    r_bmask = (st_r.r_flow || (st_r.r_pref && ini_phase && !r_tdn)) ? MASK_4KB
                                                     : st_r.r_mask;
    case (st_r.rd_st)
      R_IDLE: begin
        if (rd_start && (rd_cmd == CMD_IO_RD || rd_cmd == CMD_CFG_RD ||
            rd_cmd == CMD_MEM_RD || rd_cmd == CMD_MEM_RDL ||
            rd_cmd == CMD_MEM_RDM)) begin
          st_nxt.rd_st   = R_FETCH;
          st_nxt.r_addr  = rd_addr;
          st_nxt.r_fcnt  = 11'h0;
          st_nxt.r_dcnt  = 11'h0;
          st_nxt.r_tdone = 1'b0;
          st_nxt.r_flow  = 1'b0;
          st_nxt.r_istop = 1'b0;
          st_nxt.r_pref  = (rd_cmd == CMD_MEM_RDL) ||
                           (rd_cmd == CMD_MEM_RDM) ||
                           (rd_cmd == CMD_MEM_RD &&
                            (rd_upstream ? st_r.chip_ctrl[UP_PREF_BIT]
                                         : rd_pref_space));
          if (!st_nxt.r_pref) begin
            st_nxt.r_mask = MASK_ONE_DW;
            st_nxt.r_be   = rd_be;
          end else begin
            st_nxt.r_be = BE_ALL_ON;
            if (rd_cmd == CMD_MEM_RDM) begin
              st_nxt.r_mask = cls_ok ? {line_mask[8:0], 1'b1}
                                     : MASK_32DW;
            end else begin
              st_nxt.r_mask = cls_ok ? line_mask : MASK_16DW;
            end
          end
          st_nxt.r_tlast = ((rd_addr[9:0] + 10'h1) & st_nxt.r_mask) ==
                           10'h0;
        end
      end
      R_FETCH, R_DRAIN: begin
        st_nxt.r_addr  = r_na;
        st_nxt.r_fcnt  = r_fn;
        st_nxt.r_dcnt  = r_dn;
        st_nxt.r_tdone = r_tdn;
        if (st_r.rd_st == R_FETCH && st_r.r_pref && ini_phase && !r_tdn) begin
          st_nxt.r_flow = 1'b1;
        end
        if (r_tdn) begin
          st_nxt.rd_st   = R_DRAIN;
          st_nxt.r_tlast = 1'b0;
        end else if (ini_end && st_nxt.r_flow) begin
          st_nxt.r_tlast = 1'b1;
        end else begin
          st_nxt.r_tlast = ((r_na[9:0] + 10'h1) & r_bmask) == 10'h0;
        end
        // Stop the initiator on the last dword held, or when flow stalls
        st_nxt.r_istop = (r_tdn || st_nxt.r_flow) &&
                         (r_dn + 11'h1 >= r_fn) && (r_fn != r_dn);
        if (ini_end || (ini_phase && st_r.r_istop)) begin
          st_nxt.rd_st     = R_IDLE;
          st_nxt.r_istop   = 1'b0;
          st_nxt.r_tlast   = 1'b0;
          st_nxt.r_flow    = 1'b0;
          st_nxt.r_discard = (r_fn != r_dn) || !r_tdn;
        end
      end
      default: st_nxt.rd_st = R_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r           <= '0;
      st_r.wr_st     <= W_IDLE;
      st_r.rd_st     <= R_IDLE;
      st_r.chip_ctrl <= CHIP_CTRL_RST;
      st_r.cache_line_length       <= CLS_RST;
      st_r.cmd_hi    <= CMD_HI_RST;
      st_r.brctl_lo  <= BRCTL_LO_RST;
      st_r.w_mask    <= MASK_4KB;
      st_r.w_lmask   <= MASK_4KB;
      st_r.r_be      <= BE_ALL_ON;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign cfg_rdata   = st_r.rdata;
  assign wr_ack      = st_r.w_ack;
  assign wr_disc     = st_r.w_disc;
  assign wr_retry    = st_r.w_retry;
  assign wr_as_mw    = st_r.w_as_mw;
  assign rd_prefetch = st_r.r_pref;
  assign rd_be_out   = st_r.r_be;
  assign rd_tgt_addr = st_r.r_addr;
  assign rd_tgt_last = st_r.r_tlast;
  assign rd_ini_stop = st_r.r_istop;
  assign rd_flow     = st_r.r_flow;
  assign rd_discard  = st_r.r_discard;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  a_dly_single_phase: assert property (
    st_r.wr_st == W_DLY |-> (wr_ack && wr_disc) and
    (wr_phase |=> !wr_ack))
    else $error("delayed write not ended after one phase");
  a_dly_entry_free: assert property (
    st_r.wr_st == W_IDLE && wr_start && wr_cmd == CMD_CFG_WR && !dtq_free
    |=> wr_retry && !wr_ack)
    else $error("delayed write taken without a free entry");
  a_post_retry_full: assert property (
    st_r.wr_st == W_IDLE && wr_start && wr_cmd == CMD_MEM_WR &&
    pw_free_dw == '0 |=> wr_retry ##1 !wr_retry)
    else $error("posted write without room not retried");
  a_post_4k_disc: assert property (
    st_r.wr_st == W_POST && st_r.w_addr[9:0] == 10'h3ff |-> wr_disc)
    else $error("posted write crossed a 4KB boundary");
  a_post_full_disc: assert property (
    st_r.wr_st == W_POST && !wr_phase && pw_free_dw == PW_W'(1)
    |=> st_r.wr_st != W_POST || wr_disc)
    else $error("full posted buffer without disconnect");
  a_pref_be_on: assert property (
    st_r.rd_st != R_IDLE && rd_prefetch |-> rd_be_out == BE_ALL_ON)
    else $error("prefetch read with byte enables off");
  a_nonpref_one_dw: assert property (
    st_r.rd_st == R_FETCH && !rd_prefetch |-> rd_tgt_last)
    else $error("non-prefetch read fetching more than one dword");
  a_rd_4k_stop: assert property (
    st_r.rd_st == R_FETCH && rd_tgt_addr[9:0] == 10'h3ff |-> rd_tgt_last)
    else $error("read prefetch crossed a 4KB boundary");
  a_flow_cause: assert property (
    $rose(rd_flow) |-> $past(ini_phase && st_r.rd_st == R_FETCH))
    else $error("flow-through entered without initiator data");

  c_post_disc: cover property (wr_ack && wr_disc && wr_phase &&
                               st_r.wr_st == W_POST);
  c_fb2b_retry: cover property (wr_start && wr_fb2b ##1 wr_retry);
  c_flow: cover property ($rose(rd_flow));
  c_discard: cover property (rd_discard && rd_prefetch);

endmodule

/* rtl/bridge_bound_pkg.sv */
// Constants for the write disconnect and read prefetch boundary block.
// Assumes byte-wide configuration access and dword addresses from the core.
package bridge_bound_pkg;

  // Configuration space byte offsets
  localparam logic [7:0] CLS_OFS       = 8'h0c;
  localparam logic [7:0] CMD_HI_OFS    = 8'h05;
  localparam logic [7:0] BRCTL_LO_OFS  = 8'h3e;
  localparam logic [7:0] CHIP_CTRL_OFS = 8'h40;
  localparam logic [7:0] STATUS_OFS    = 8'h41;

  // Reset values
  localparam logic [7:0] CLS_RST       = 8'h00;
  localparam logic [7:0] CMD_HI_RST    = 8'h00;
  localparam logic [7:0] BRCTL_LO_RST  = 8'h00;
  localparam logic [7:0] CHIP_CTRL_RST = 8'h00;

  // Field positions
  localparam int MWD_BIT      = 1;  // Chip control: posted write disconnect
  localparam int UP_PREF_BIT  = 2;  // Chip control: upstream read prefetch
  localparam int FB2B_CMD_BIT = 1;  // Command register high byte
  localparam int FB2B_BRC_BIT = 7;  // Bridge control low byte

  // Bus commands
  localparam logic [3:0] CMD_IO_RD   = 4'h2;
  localparam logic [3:0] CMD_IO_WR   = 4'h3;
  localparam logic [3:0] CMD_MEM_RD  = 4'h6;
  localparam logic [3:0] CMD_MEM_WR  = 4'h7;
  localparam logic [3:0] CMD_CFG_RD  = 4'ha;
  localparam logic [3:0] CMD_CFG_WR  = 4'hb;
  localparam logic [3:0] CMD_MEM_RDM = 4'hc;
  localparam logic [3:0] CMD_MEM_RDL = 4'he;
  localparam logic [3:0] CMD_MEM_WRI = 4'hf;

  // Boundary masks in dwords, low ten address bits
  localparam logic [9:0] MASK_4KB    = 10'h3ff;
  localparam logic [9:0] MASK_16DW   = 10'h00f;
  localparam logic [9:0] MASK_32DW   = 10'h01f;
  localparam logic [9:0] MASK_ONE_DW = 10'h000;

  // Byte enables forced on for prefetch (active low)
  localparam logic [3:0] BE_ALL_ON = 4'h0;

  typedef enum logic [1:0] {
    W_IDLE = 2'b00,
    W_POST = 2'b01,
    W_DLY  = 2'b11
  } wr_st_t;

  typedef enum logic [1:0] {
    R_IDLE  = 2'b00,
    R_FETCH = 2'b01,
    R_DRAIN = 2'b11
  } rd_st_t;

endpackage

/* tb/far_target.sv */
// Far-side target model answering the bridge's target-side read phases.
// Assumes the bench raises go once a read request has been taken.
module far_target (
  input  wire logic       clk,
  input  wire logic       go,
  input  wire logic       slow,
  input  wire logic [7:0] stop_at,
  input  wire logic       last,
  output logic            tgt_phase,
  output logic            tgt_stop
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] n = 8'h00;
  logic       tick = 1'b0;
  logic       fin = 1'b0;
  initial begin
    tgt_phase = 1'b0;
    tgt_stop = 1'b0;
  end
  // One phase a cycle, or every other cycle when slow; stop_at ends early
  always @(posedge clk) begin
    if (tgt_phase) n = n + 8'h01;
    fin = fin || (tgt_phase && (last || tgt_stop));
    #1;
    if (!go) begin
      n = 8'h00;
      fin = 1'b0;
    end
    tick = ~tick;
    tgt_phase = go && !fin && (!slow || tick);
    tgt_stop = tgt_phase && (n + 1 == stop_at);
  end
endmodule

/* tb/test_bridge_write_disconnect_read_prefetch.sv */
// Self-checking bench for the write disconnect and read prefetch block.
// Assumes far_target as the target seen by forwarded reads.
`define CHK(nm, e, o) \
  begin \
    compares++; \
    if ((o) !== (e)) begin \
      n_mismatch++; \
      $display("CHECK FAILED %s expected %h seen %h", nm, e, o); \
    end \
  end

module test_bridge_write_disconnect_read_prefetch
  import bridge_bound_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk = 1'b0, rst = 1'b1, cfg_wr = 1'b0, cfg_rd = 1'b0;
  logic [7:0]  cfg_addr = 8'h00, cfg_wdata = 8'h00, cfg_rdata;
  logic        wr_start = 1'b0, wr_upstream = 1'b0, wr_fb2b = 1'b0;
  logic        wr_phase = 1'b0, wr_last = 1'b0, dtq_free = 1'b1;
  logic [3:0]  wr_cmd = 4'h0, rd_cmd = 4'h0, rd_be = 4'h0, rd_be_out;
  logic [29:0] wr_addr = 30'h0, rd_addr = 30'h0, rd_tgt_addr;
  logic [7:0]  pw_free_dw = 8'h00, stop_at = 8'h00;
  logic        rd_start = 1'b0, rd_upstream = 1'b0, rd_pref_space = 1'b0;
  logic        ini_phase = 1'b0, ini_end = 1'b0, go = 1'b0, slow = 1'b0;
  logic        tgt_phase, tgt_stop, wr_ack, wr_disc, wr_retry, wr_as_mw;
  logic        rd_prefetch, rd_tgt_last, rd_ini_stop, rd_flow, rd_discard;
  logic [7:0]  chip = 8'h00, cache_line_length = 8'h00, cmdhi = 8'h00, brc = 8'h00;
  logic [7:0]  wc = 8'h00, tc = 8'h00, ic = 8'h00;
  logic        rd_seen = 1'b0;
  logic [31:0] q[$];
  logic [31:0] seed = 32'h60633637;
  logic [7:0]  cv[5] = '{8'h00, 8'h04, 8'h10, 8'h03, 8'h01};
  logic [3:0]  rc[6] = '{CMD_IO_RD, CMD_CFG_RD, CMD_MEM_RD, CMD_MEM_RD,
                         CMD_MEM_RDL, CMD_MEM_RDM};
  int          n_mismatch = 0, compares = 0;

  bridge_bound_ctl dut_u (.clk(clk), .rst(rst), .cfg_wr(cfg_wr),
    .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
    .cfg_rdata(cfg_rdata), .wr_start(wr_start), .wr_cmd(wr_cmd),
    .wr_addr(wr_addr), .wr_upstream(wr_upstream), .wr_fb2b(wr_fb2b),
    .wr_phase(wr_phase), .wr_last(wr_last), .pw_free_dw(pw_free_dw),
    .dtq_free(dtq_free), .wr_ack(wr_ack), .wr_disc(wr_disc),
    .wr_retry(wr_retry), .wr_as_mw(wr_as_mw), .rd_start(rd_start),
    .rd_cmd(rd_cmd), .rd_addr(rd_addr), .rd_be(rd_be),
    .rd_upstream(rd_upstream), .rd_pref_space(rd_pref_space),
    .tgt_phase(tgt_phase), .tgt_stop(tgt_stop), .ini_phase(ini_phase),
    .ini_end(ini_end), .rd_prefetch(rd_prefetch), .rd_be_out(rd_be_out),
    .rd_tgt_addr(rd_tgt_addr), .rd_tgt_last(rd_tgt_last),
    .rd_ini_stop(rd_ini_stop), .rd_flow(rd_flow),
    .rd_discard(rd_discard));
  far_target far_u (.clk(clk), .go(go), .slow(slow), .stop_at(stop_at),
    .last(rd_tgt_last), .tgt_phase(tgt_phase), .tgt_stop(tgt_stop));

  always #5 clk = ~clk;

  task automatic give_verdict();
    if (n_mismatch == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  function automatic logic cls_ok(input logic [7:0] c);
    return c inside {8'h01, 8'h02, 8'h04, 8'h08, 8'h10};
  endfunction

  task automatic note(input logic [31:0] o);
    logic [31:0] e;
    e = (q.size() != 0) ? q.pop_front() : 32'hffffffff;
    `CHK("result", e, o)
  endtask

  // Results: 1 config read, 2 write end, 3 fetch end, 4 delivery, 5 drop
  always @(posedge clk) begin
    if (!rst) begin
      if (rd_seen) note({4'h1, 20'h0, cfg_rdata});
      rd_seen = cfg_rd;
      if (wr_retry === 1'b1) note({4'h2, 18'h0, 1'b1, 9'h0});
      if (wr_ack === 1'b1 && wr_phase) begin
        wc = wc + 8'h01;
        if (wr_disc || wr_last) begin
          note({4'h2, 18'h0, 1'b0, wr_disc, wc});
          wc = 8'h00;
        end
      end
      if (tgt_phase) begin
        tc = tc + 8'h01;
        if (rd_tgt_last || tgt_stop) begin
          note({4'h3, 4'h0, rd_tgt_addr[9:0], rd_flow, rd_prefetch,
                rd_be_out, tc});
          tc = 8'h00;
        end
      end
      if (ini_phase) ic = ic + 8'h01;
      if (ini_phase && rd_ini_stop === 1'b1) begin
        note({4'h4, 20'h0, ic});
        ic = 8'h00;
      end
      if (rd_discard === 1'b1) note({4'h5, 28'h0});
    end
  end

  task automatic cfg_w(input logic [7:0] a, d);
    @(posedge clk);
    #1;
    cfg_wr = 1'b1;
    cfg_addr = a;
    cfg_wdata = d;
    @(posedge clk);
    #1;
    cfg_wr = 1'b0;
    case (a)
      CLS_OFS: cache_line_length = d;
      CMD_HI_OFS: cmdhi = d;
      BRCTL_LO_OFS: brc = d;
      CHIP_CTRL_OFS: chip = d;
      default: ;
    endcase
  endtask

  task automatic cfg_r(input logic [7:0] a, e);
    q.push_back({4'h1, 20'h0, e});
    @(posedge clk);
    #1;
    cfg_rd = 1'b1;
    cfg_addr = a;
    @(posedge clk);
    #1;
    cfg_rd = 1'b0;
    @(posedge clk);
    #1;
  endtask

  task automatic do_wr(input logic [3:0] c, input logic [29:0] a,
                       input logic up, fb, input logic [7:0] f0, input int n);
    logic       pst, ok;
    logic [9:0] m;
    int         lim, k;
    pst = (c == CMD_MEM_WR || c == CMD_MEM_WRI);
    m = (c == CMD_MEM_WR && chip[MWD_BIT] && cls_ok(cache_line_length)) ?
        10'(cache_line_length - 8'h01) : MASK_4KB;
    lim = (!pst || f0 <= 8'h01) ? 1 : int'(m - (a[9:0] & m)) + 1;
    ok = pst ? (f0 != 8'h00) : dtq_free;
    if (fb) ok = ok && (up ? cmdhi[FB2B_CMD_BIT] : brc[FB2B_BRC_BIT]);
    if (ok) q.push_back({4'h2, 18'h0, 1'b0, 1'(lim <= n),
                         8'(lim < n ? lim : n)});
    else q.push_back({4'h2, 18'h0, 1'b1, 9'h0});
    @(posedge clk);
    #1;
    wr_start = 1'b1;
    wr_cmd = c;
    wr_addr = a;
    wr_upstream = up;
    wr_fb2b = fb;
    pw_free_dw = f0;
    @(posedge clk);
    #1;
    wr_start = 1'b0;
    for (k = 0; k < 70 && wr_ack === 1'b1; k++) begin
      wr_phase = 1'b1;
      wr_last = (k == n - 1);
      @(posedge clk);
      #1;
    end
    wr_phase = 1'b0;
    wr_last = 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic do_rd(input logic [3:0] c, input logic up, ps,
                       input logic [7:0] stp, input logic quit, fl = 1'b0);
    logic       pf, done;
    logic [9:0] m;
    int         n, k;
    rd_addr = 30'($random(seed));
    if (fl) rd_addr[9:0] = 10'h3e0;
    rd_be = 4'($random(seed));
    slow = fl ? 1'b0 : 1'($random(seed));
    pf = c == CMD_MEM_RDL || c == CMD_MEM_RDM ||
         (c == CMD_MEM_RD && (up ? chip[UP_PREF_BIT] : ps));
    if (!pf) m = MASK_ONE_DW;
    else if (c == CMD_MEM_RDM) m = cls_ok(cache_line_length) ? 10'(2 * cache_line_length - 1) : MASK_32DW;
    else m = cls_ok(cache_line_length) ? 10'(cache_line_length - 8'h01) : MASK_16DW;
    if (fl) m = MASK_4KB;
    n = int'(m - (rd_addr[9:0] & m)) + 1;
    if (stp != 8'h00 && int'(stp) < n) n = int'(stp);
    q.push_back({4'h3, 4'h0, 10'(rd_addr[9:0] + n - 1), fl, pf,
                 pf ? BE_ALL_ON : rd_be, 8'(n)});
    if (quit) q.push_back({4'h5, 28'h0});
    else q.push_back({4'h4, 20'h0, 8'(n)});
    rd_start = 1'b1;
    rd_cmd = c;
    rd_upstream = up;
    rd_pref_space = ps;
    stop_at = stp;
    @(posedge clk);
    #1;
    rd_start = 1'b0;
    go = 1'b1;
    k = 0;
    // In flow-through the initiator takes data every other cycle
    do begin
      @(posedge clk);
      done = tgt_phase && (rd_tgt_last || tgt_stop);
      #1;
      ini_phase = fl && !done && tc != 8'h00 && !ini_phase;
    end while (!done && ++k < 80);
    go = 1'b0;
    ini_end = quit;
    ini_phase = !quit;
    k = 0;
    do @(posedge clk);
    while (!quit && rd_ini_stop !== 1'b1 && ++k < 80);
    #1;
    ini_end = 1'b0;
    ini_phase = 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask

  initial begin
    #300000;
    n_mismatch++;
    give_verdict();
  end

  initial begin
    repeat (10) @(posedge clk);
    #1;
    rst = 1'b0;
    cfg_r(CLS_OFS, CLS_RST);
    cfg_r(CMD_HI_OFS, CMD_HI_RST);
    cfg_r(BRCTL_LO_OFS, BRCTL_LO_RST);
    cfg_r(CHIP_CTRL_OFS, CHIP_CTRL_RST);
    cfg_r(8'h80, 8'h00);
    do_wr(CMD_MEM_WR, 30'h3fe, 1'b0, 1'b0, 8'h40, 40);
    do_wr(CMD_MEM_WR, 30'h1234, 1'b0, 1'b0, 8'h40, 3);
    cfg_w(CLS_OFS, 8'h08);
    cfg_w(CHIP_CTRL_OFS, 8'h02);
    cfg_r(CHIP_CTRL_OFS, 8'h02);
    do_wr(CMD_MEM_WR, 30'h5, 1'b0, 1'b0, 8'h40, 40);
    do_wr(CMD_MEM_WRI, 30'h3fa, 1'b0, 1'b0, 8'h40, 40);
    do_wr(CMD_MEM_WRI, 30'h10, 1'b0, 1'b0, 8'h01, 40);
    cfg_r(STATUS_OFS, 8'h10);
    do_wr(CMD_MEM_WR, 30'h10, 1'b0, 1'b0, 8'h01, 40);
    do_wr(CMD_MEM_WR, 30'h10, 1'b0, 1'b0, 8'h00, 40);
    do_wr(CMD_IO_WR, 30'h7, 1'b0, 1'b0, 8'h00, 4);
    do_wr(CMD_CFG_WR, 30'h9, 1'b1, 1'b0, 8'h00, 4);
    dtq_free = 1'b0;
    do_wr(CMD_IO_WR, 30'h7, 1'b0, 1'b0, 8'h40, 4);
    dtq_free = 1'b1;
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < 2; i++) begin
        do_wr(CMD_MEM_WR, 30'h20, 1'(i), 1'b1, 8'h40, 2);
        do_wr(CMD_MEM_WR, 30'h20, 1'(i), 1'b1, 8'h00, 2);
      end
      cfg_w(CMD_HI_OFS, 8'h02);
      cfg_w(BRCTL_LO_OFS, 8'h80);
    end
    foreach (cv[i]) begin
      cfg_w(CLS_OFS, cv[i]);
      foreach (rc[j])
        do_rd(rc[j], 1'b0, 1'(j), 8'h00, 1'b0);
    end
    do_rd(CMD_MEM_RD, 1'b1, 1'b1, 8'h00, 1'b0);
    cfg_w(CHIP_CTRL_OFS, 8'h06);
    do_rd(CMD_MEM_RD, 1'b1, 1'b0, 8'h00, 1'b0);
    cfg_w(CLS_OFS, 8'h10);
    do_rd(CMD_MEM_RDM, 1'b0, 1'b0, 8'h01, 1'b0);
    do_rd(CMD_MEM_RDL, 1'b0, 1'b1, 8'h00, 1'b1);
    do_rd(CMD_MEM_RDL, 1'b0, 1'b1, 8'h00, 1'b0, 1'b1);
    repeat (4) @(posedge clk);
    `CHK("queue", 32'h0, 32'(q.size()))
    give_verdict();
  end
endmodule
